// file: rtl/global_interrupt_flags_masks.sv
// Global event flags, masks and active-low interrupt line
// Contract
// - Dropout event sets flag bit 6, held until the register is read.
// - Second thermal alarm sets flag bit 5, held until read.
// - First thermal alarm sets flag bit 4, held until read.
// - On-key rising edge sets flag bit 3, cleared only by reading or system reset.
// - On-key falling edge sets flag bit 2, cleared only by reading or system reset.
// - General input rising edge sets flag bit 1, cleared by reading.
// - General input falling edge sets flag bit 0, cleared by reading.
// - General input edges count only while the pin is an input.
// - Unmasked dropout flag rising 0 to 1 pulls the line low.
// - Mask bits 5 and 4 gate the thermal alarm flags.
// - Mask bits 3 and 2 gate the on-key edge flags.
// - Mask bits 1 and 0 gate the general input edge flags.
// - Line returns high only once every flag is cleared.
// - A set mask bit blocks the line but the flag still latches.
// - Status bit 0 reads the gate drive level after masking.
module global_interrupt_flags_masks
  import glbl_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic system_reset_condition,
  input wire logic dropout_event,
  input wire logic thermal_threshold_one,
  input wire logic thermal_threshold_two,
  input wire logic onkey_input,
  input wire logic gpio_pin_in,
  input wire logic gpio_is_input,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic interrupt_line_n
);
  logic rst_meta_q;
  logic rst_n;
  logic [7:0] global_event_flags_q;
  logic [7:0] global_event_flags_d;
  logic [7:0] global_event_masks_q;
  logic [7:0] reg_rdata_q;
  logic [7:0] reg_rdata_d;
  logic irq_q;
  logic irq_d;
  logic therm_one_prev_q;
  logic therm_two_prev_q;
  logic dropout_prev_q;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  wire onkey_rise_flag_ev;
  wire onkey_fall_flag_ev;
  wire gpi_rise_ev;
  wire gpi_fall_ev;
  wire [7:0] event_vec;
  wire [7:0] new_unmasked;
  wire rd_flags;
  wire rd_masks;
  wire rd_status;
  wire wr_masks;
  wire [7:0] status_vec;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  pin_edge_detect #(
    .WIDTH(2)
  ) pin_edge_detect_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in({onkey_input, gpio_pin_in}),
    .rise_pulse(pin_rise),
    .fall_pulse(pin_fall)
  );

  assign onkey_rise_flag_ev = pin_rise[1];
  assign onkey_fall_flag_ev = pin_fall[1];
  assign gpi_rise_ev = pin_rise[0] & gpio_is_input;
  assign gpi_fall_ev = pin_fall[0] & gpio_is_input;

  // Detector levels from the analog side share this clock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dropout_prev_q <= 1'b0;
      therm_one_prev_q <= 1'b0;
      therm_two_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      dropout_prev_q <= dropout_event;
      therm_one_prev_q <= thermal_threshold_one;
      therm_two_prev_q <= thermal_threshold_two;
    end
  end

  // Bit 7 never sets; reads of it return zero
  assign event_vec = {1'b0,
    dropout_event & ~dropout_prev_q,
    thermal_threshold_two & ~therm_two_prev_q,
    thermal_threshold_one & ~therm_one_prev_q,
    onkey_rise_flag_ev, onkey_fall_flag_ev, gpi_rise_ev, gpi_fall_ev};

  assign rd_flags = clk_en & reg_rd & (reg_addr == FLAGS_ADDR);
  assign rd_masks = clk_en & reg_rd & (reg_addr == MASKS_ADDR);
  assign rd_status = clk_en & reg_rd & (reg_addr == STATUS_ADDR);
  assign wr_masks = clk_en & reg_wr & (reg_addr == MASKS_ADDR);

  // Set wins over the read clear
  assign global_event_flags_d =
    (rd_flags ? FLAGS_RESET : global_event_flags_q) | event_vec;

  // Only a 0 to 1 change of an unmasked flag asserts
  assign new_unmasked = event_vec & ~global_event_flags_q
    & ~global_event_masks_q;

  // Line stays low until all flags are gone
  assign irq_d = (|new_unmasked) ? 1'b1 :
    ((global_event_flags_d == ZERO_BYTE) ? 1'b0 : irq_q);

  assign status_vec = {7'h00, irq_q};

  assign reg_rdata_d = rd_flags ? {1'b0, global_event_flags_q[6:0]} :
    rd_masks ? global_event_masks_q :
    rd_status ? status_vec :
    ZERO_BYTE;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      global_event_flags_q <= FLAGS_RESET;
      global_event_masks_q <= MASKS_RESET;
      irq_q <= 1'b0;
      reg_rdata_q <= ZERO_BYTE;
    end
    else if (clk_en)
    begin
      if (system_reset_condition)
      begin
        global_event_flags_q <= FLAGS_RESET;
        global_event_masks_q <= MASKS_RESET;
        irq_q <= 1'b0;
      end
      else
      begin
        global_event_flags_q <= global_event_flags_d;
        if (wr_masks)
        begin
          global_event_masks_q <= reg_wdata;
        end
        irq_q <= irq_d;
      end
      if (reg_rd)
      begin
        reg_rdata_q <= reg_rdata_d;
      end
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign interrupt_line_n = ~irq_q;

  chk_read_clears: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rd_flags && event_vec == ZERO_BYTE && !system_reset_condition)
    |=> global_event_flags_q == ZERO_BYTE)
    else $error("flags not cleared by read");

  chk_event_latches: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !system_reset_condition && event_vec != ZERO_BYTE)
    |=> (global_event_flags_q & $past(event_vec)) == $past(event_vec))
    else $error("event did not latch its flag");

  chk_set_wins_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rd_flags && !system_reset_condition)
    |=> global_event_flags_q == $past(event_vec))
    else $error("event lost during clearing read");

  chk_irq_asserts: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !system_reset_condition && new_unmasked != ZERO_BYTE)
    |=> !interrupt_line_n)
    else $error("unmasked flag did not pull the line low");

  chk_irq_release: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (global_event_flags_q == ZERO_BYTE) |-> interrupt_line_n)
    else $error("line low with no flag set");

  chk_irq_holds: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (irq_q && global_event_flags_d != ZERO_BYTE && clk_en
      && !system_reset_condition) |=> irq_q)
    else $error("line released while flags remain");

  chk_masked_quiet: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!irq_q && new_unmasked == ZERO_BYTE) |=> !irq_q)
    else $error("masked flag pulled the line low");

  chk_gpi_gated: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!gpio_is_input && !rd_flags && !system_reset_condition)
    |=> global_event_flags_q[1:0] == $past(global_event_flags_q[1:0]))
    else $error("general input edge taken while not an input");

  chk_one_per_edge: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (pin_rise != 2'b00) |=> (pin_rise & $past(pin_rise)) == 2'b00)
    else $error("one edge gave two pulses");

  chk_status_level: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rd_status |=> reg_rdata[STAT_IRQ_BIT] == $past(irq_q))
    else $error("status bit disagrees with gate drive");

  chk_system_reset_condition_defaults: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && system_reset_condition) |=> (global_event_flags_q ==
      FLAGS_RESET && global_event_masks_q == MASKS_RESET
      && interrupt_line_n))
    else $error("system reset did not restore defaults");

  cov_irq_cycle: cover property (@(posedge clk_sys) disable iff (!rst_n)
    !interrupt_line_n ##1 rd_flags ##1 interrupt_line_n);
  cov_set_on_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rd_flags && event_vec != ZERO_BYTE);
  cov_masked_event: cover property (@(posedge clk_sys) disable iff (!rst_n)
    event_vec != ZERO_BYTE && new_unmasked == ZERO_BYTE);
  cov_onkey_edges: cover property (@(posedge clk_sys) disable iff (!rst_n)
    onkey_rise_flag_ev ##[1:20] onkey_fall_flag_ev);
endmodule : global_interrupt_flags_masks

// file: pkg/glbl_irq_pkg.sv
// Constants shared by the global event flag and mask block
package glbl_irq_pkg;
  localparam int REG_W = 8;
  localparam logic [7:0] FLAGS_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h05;
  localparam logic [7:0] MASKS_ADDR = 8'h06;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASKS_RESET = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int DROPOUT_BIT = 6;
  localparam int THERM_TWO_BIT = 5;
  localparam int THERM_ONE_BIT = 4;
  localparam int ONKEY_RISE_BIT = 3;
  localparam int ONKEY_FALL_BIT = 2;
  localparam int GPI_RISE_BIT = 1;
  localparam int GPI_FALL_BIT = 0;
  localparam int STAT_IRQ_BIT = 0;
  localparam int SYNC_STAGES = 2;
endpackage : glbl_irq_pkg

// file: rtl/pin_edge_detect.sv
// Two-flop pin synchroniser with rise and fall pulse detection
module pin_edge_detect
  import glbl_irq_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] rise_pulse,
  output logic [WIDTH-1:0] fall_pulse
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;
  logic [SYNC_STAGES:0] fill_q;
  wire armed;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_edge_detect: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
      fill_q <= '0;
    end
    else if (clk_en)
    begin
      fill_q <= {fill_q[SYNC_STAGES-1:0], 1'b1};
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // No pulse until the chain holds the pin level, so a high idle pin
  // gives no false edge after reset
  assign armed = fill_q[SYNC_STAGES];

  // One pulse per settled edge
  assign rise_pulse = sync_q & ~prev_q & {WIDTH{clk_en & armed}};
  assign fall_pulse = ~sync_q & prev_q & {WIDTH{clk_en & armed}};
endmodule : pin_edge_detect

// file: sim/host_model.sv
// Host model driving the register port of the global event block
module host_model
(
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Entered just after a falling edge; strobe spans one rising edge,
  // then one idle edge passes before the next request
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_addr = addr;
    reg_wdata = {1'b0, data[6:0]};
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    data = reg_rdata;
    @(negedge clk_sys);
  endtask : rd
endmodule : host_model

// file: sim/global_interrupt_flags_masks_tb.sv
// Self-checking bench for the global event flag and mask block
module global_interrupt_flags_masks_tb import glbl_irq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic arst_n, clk_en, src, dropout_event, th_one, th_two;
  logic onkey_input, gpio_pin_in, gpio_is_input, reg_wr, reg_rd;
  logic interrupt_line_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, flags_m, masks_m;
  logic irq_m;
  logic [31:0] seed = 32'h0000000A;
  int bad_count = 0;
  int n_compared = 0;
  always #4 clk_sys = ~clk_sys;
  global_interrupt_flags_masks global_interrupt_flags_masks_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .system_reset_condition(src), .dropout_event(dropout_event),
    .thermal_threshold_one(th_one), .thermal_threshold_two(th_two),
    .onkey_input(onkey_input), .gpio_pin_in(gpio_pin_in),
    .gpio_is_input(gpio_is_input), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .interrupt_line_n(interrupt_line_n));
  host_model host_model_inst (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_line();
    n_compared++;
    if (interrupt_line_n !== ~irq_m)
    begin
      bad_count++;
      $display("BAD %0t line %b", $time, interrupt_line_n);
    end
  endtask : chk_line
  task automatic set_flag(input int b);
    if (!flags_m[b] && !masks_m[b])
      irq_m = 1'b1;
    flags_m[b] = 1'b1;
  endtask : set_flag
  task automatic rd_flags();
    logic [7:0] d;
    host_model_inst.rd(FLAGS_ADDR, d);
    chk_byte(d, flags_m);
    flags_m = FLAGS_RESET;
    irq_m = 1'b0;
    chk_line();
  endtask : rd_flags
  // Pulses detectors and toggles pins, then lets the synchronisers settle
  task automatic fire(input logic [6:0] ev);
    dropout_event = ev[6];
    th_two = ev[5];
    th_one = ev[4];
    if (ev[3])
      onkey_input = ~onkey_input;
    if (ev[1])
      gpio_pin_in = ~gpio_pin_in;
    @(negedge clk_sys);
    dropout_event = 1'b0;
    th_two = 1'b0;
    th_one = 1'b0;
    for (int b = THERM_ONE_BIT; b <= DROPOUT_BIT; b++)
      if (ev[b])
        set_flag(b);
    if (ev[3])
      set_flag(onkey_input ? ONKEY_RISE_BIT
        : ONKEY_FALL_BIT);
    if (ev[1] && gpio_is_input)
      set_flag(gpio_pin_in ? GPI_RISE_BIT
        : GPI_FALL_BIT);
    repeat (6) @(negedge clk_sys);
  endtask : fire
  initial
  begin
    #200us;
    bad_count++;
    end_sim();
  end
  initial
  begin
    logic [7:0] d;
    logic [31:0] r;
    arst_n = 1'b0;
    clk_en = 1'b1;
    src = 1'b0;
    dropout_event = 1'b0;
    th_one = 1'b0;
    th_two = 1'b0;
    onkey_input = 1'b1;
    gpio_pin_in = 1'b0;
    gpio_is_input = 1'b1;
    flags_m = FLAGS_RESET;
    masks_m = MASKS_RESET;
    irq_m = 1'b0;
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd_flags();
    host_model_inst.rd(MASKS_ADDR, d);
    chk_byte(d, masks_m);
    host_model_inst.rd(8'h33, d);
    chk_byte(d, ZERO_BYTE);
    fire(7'h7F);
    chk_line();
    rd_flags();
    for (int i = 0; i < 40; i++)
    begin
      r = xs();
      masks_m = {1'b0, r[6:0]};
      host_model_inst.wr(MASKS_ADDR, masks_m);
      gpio_is_input = r[7];
      host_model_inst.wr(FLAGS_ADDR, 8'h7F);
      fire(r[14:8]);
      chk_line();
      host_model_inst.rd(STATUS_ADDR, d);
      chk_byte(d, {7'h00, irq_m});
      rd_flags();
    end
    masks_m = 8'h00;
    host_model_inst.wr(MASKS_ADDR, masks_m);
    // Dropout rises on the very edge that takes the clearing read
    dropout_event = 1'b1;
    host_model_inst.rd(FLAGS_ADDR, d);
    dropout_event = 1'b0;
    chk_byte(d, flags_m);
    flags_m = FLAGS_RESET;
    set_flag(DROPOUT_BIT);
    chk_line();
    rd_flags();
    // Mask write refused while the clock enable is low
    clk_en = 1'b0;
    host_model_inst.wr(MASKS_ADDR, 8'h12);
    clk_en = 1'b1;
    host_model_inst.rd(MASKS_ADDR, d);
    chk_byte(d, masks_m);
    fire(7'h50);
    chk_line();
    src = 1'b1;
    @(negedge clk_sys);
    src = 1'b0;
    @(negedge clk_sys);
    flags_m = FLAGS_RESET;
    masks_m = MASKS_RESET;
    irq_m = 1'b0;
    chk_line();
    rd_flags();
    host_model_inst.rd(MASKS_ADDR, d);
    chk_byte(d, masks_m);
    end_sim();
  end
endmodule : global_interrupt_flags_masks_tb
